// *** dv/test_watchdog_mode_control.sv ***
/*
  Self-checking bench for wdmc_top: register access, modes, timeouts, clears.
  Assumes the package offsets and a stand-in oscillator of 80 ns period.
*/
`timescale 1ns/10ps
module test_watchdog_mode_control import wdmc_pkg::*;;
  logic        clk_i = 0, rst_i = 1, lfosc_i = 0, sleep_i = 0, watchdog_clear_instr_i = 0;
  logic        osc_fail_i = 0, ost_running_i = 0, cyc_i = 0, stb_i = 0, we_i = 0;
  logic        ack_o, wdt_reset_o, wake_o, active_o, timeout_flag_o, powerdown_flag_o, irq_o;
  logic [1:0]  mode_cfg_i = 2'h3;
  logic [2:0]  lf_div = 3'h0;
  logic [3:0]  sel_i = 4'hf;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
  int          failures = 0, n_checks = 0, n, e;

  always #5 clk_i = ~clk_i;
  // Stand-in oscillator, eight clocks a period
  always @(posedge clk_i) begin
    lf_div <= lf_div + 3'h1;
    lfosc_i <= lf_div[2];
  end

  wdmc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .lfosc_i(lfosc_i), .mode_cfg_i(mode_cfg_i),
    .sleep_i(sleep_i), .watchdog_clear_instr_i(watchdog_clear_instr_i), .osc_fail_i(osc_fail_i),
    .ost_running_i(ost_running_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .wdt_reset_o(wdt_reset_o), .wake_o(wake_o), .active_o(active_o),
    .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o), .irq_o(irq_o));

  task automatic complete_run();
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      failures++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    if (k >= 20) begin
      failures++;
      complete_run();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic reset_to(input logic [1:0] m);
    rst_i <= 1'b1;
    mode_cfg_i <= m;
    sleep_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Cycles until a reset or wake pulse, lim when none comes
  task automatic wait_to(input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wdt_reset_o !== 1'b1 && wake_o !== 1'b1 && n < lim);
  endtask

  initial begin
    reset_to(2'h3);
    bus(1'b0, ADR_CTRL, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0016, rd);
    bus(1'b0, ADR_STATUS, 32'h0000_0000);
    chk("status reset", 32'h0000_0000, rd);
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    sel_i <= 4'he;
    bus(1'b1, ADR_CTRL, 32'h0000_0001);
    sel_i <= 4'hf;
    bus(1'b0, ADR_CTRL, 32'h0000_0000);
    chk("write without sel0", 32'h0000_0016, rd);
    for (int m = 0; m < 4; m++) begin
      reset_to(m[1:0]);
      for (int s = 0; s < 2; s++) begin
        sleep_i <= s[0];
        repeat (2) @(posedge clk_i);
        chk("active", {31'h0, m >= 2 && !(m == 2 && s == 1)}, {31'h0, active_o});
      end
      if (m == 1) begin
        bus(1'b1, ADR_CTRL, 32'h0000_0001);
        chk("sw enable in sleep", 32'h0000_0001, {31'h0, active_o});
        wait_to(600);
        chk("sw sleep timeout", 32'h0000_0002, {30'h0, wake_o, wdt_reset_o});
      end
    end
    reset_to(2'h3);
    bus(1'b1, ADR_MASK, 32'h0000_0001);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, ADR_CTRL, 32'(p * 2));
      bus(1'b1, ADR_CMD, 32'h0000_0001);
      wait_to(2000);
      e = 248 << p;
      chk("period", 32'h0000_0001, {31'h0, n > e - 12 && n < e + 20});
      chk("reset pulse", 32'h0000_0001, {31'h0, wdt_reset_o});
      chk("flags", 32'h0000_0005, {29'h0, irq_o, powerdown_flag_o, timeout_flag_o});
      @(posedge clk_i);
      chk("pulse length", 32'h0000_0000, {31'h0, wdt_reset_o});
      bus(1'b1, ADR_STATUS, 32'h0000_0007);
      chk("cleared", 32'h0000_0000, {30'h0, irq_o, timeout_flag_o});
    end
    for (int c = 0; c < 3; c++) begin
      watchdog_clear_instr_i <= (c == 0);
      osc_fail_i <= (c == 1);
      ost_running_i <= (c == 2);
      wait_to(600);
      chk("held clear", 32'h0000_0258, 32'(n));
    end
    watchdog_clear_instr_i <= 1'b0;
    ost_running_i <= 1'b0;
    sleep_i <= 1'b1;
    wait_to(600);
    chk("sleep wake", 32'h0000_0002, {30'h0, wake_o, wdt_reset_o});
    chk("sleep flags", 32'h0000_0003, {30'h0, powerdown_flag_o, timeout_flag_o});
    bus(1'b0, ADR_STATUS, 32'h0000_0000);
    chk("sleep status", 32'h0000_0007, rd);
    reset_to(2'h2);
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    sleep_i <= 1'b1;
    wait_to(600);
    chk("off in sleep", 32'h0000_0258, 32'(n));
    complete_run();
  end

  initial begin
    #900_000;
    failures++;
    complete_run();
  end
endmodule

// *** hw/wdmc_pkg.sv ***
/*
  Constants, types and reset state for the watchdog mode control block.
  Assumes a 100 MHz system clock and a 31 kHz low frequency oscillator pin.
*/
package wdmc_pkg;

  // Time base
  localparam int unsigned LFOSC_KHZ   = 31;
  localparam int unsigned BASE_US     = 1000;
  localparam logic [4:0]  OSC_PER_MS  = 5'(LFOSC_KHZ * BASE_US / 1000);
  localparam int unsigned MS_W        = 19;
  localparam logic [4:0]  PS_MAX      = 5'h12;
  localparam logic [4:0]  PS_DEFAULT  = 5'h0b;

  // Register byte offsets
  localparam logic [7:0]  ADR_CTRL    = 8'h00;
  localparam logic [7:0]  ADR_STATUS  = 8'h04;
  localparam logic [7:0]  ADR_MASK    = 8'h08;
  localparam logic [7:0]  ADR_CMD     = 8'h0c;

  // Field positions
  localparam int unsigned CTRL_SWEN   = 0;
  localparam int unsigned CTRL_PS_LSB = 1;
  localparam int unsigned CMD_CLR     = 0;

  typedef enum logic [1:0] {
    WDMC_OFF     = 2'h0,
    WDMC_SW      = 2'h1,
    WDMC_NOSLEEP = 2'h2,
    WDMC_ON      = 2'h3
  } wdmc_mode_t;

  // Status and mask layout: bit0 timeout, bit1 powerdown, bit2 wake
  typedef struct packed {
    logic wake;
    logic pd;
    logic to;
  } wdmc_flags_t;

  typedef struct packed {
    logic [2:0]      sync;
    logic            lvl;
    wdmc_mode_t      mode;
    logic            loaded;
    logic            swen;
    logic [4:0]      ps;
    logic [4:0]      div;
    logic [MS_W-1:0] ms;
    wdmc_flags_t     st;
    wdmc_flags_t     mask;
    logic            slp;
    logic            rst_p;
    logic            wake_p;
    logic            ack;
    logic [31:0]     rdat;
  } wdmc_state_t;

  localparam logic [MS_W-1:0] MS_ZERO    = 19'h0_0000;
  localparam wdmc_flags_t     FLAGS_ZERO = 3'h0;

  localparam wdmc_state_t ST_RST = '{
    sync:   3'h0,
    lvl:    1'h0,
    mode:   WDMC_OFF,
    loaded: 1'h0,
    swen:   1'h0,
    ps:     PS_DEFAULT,
    div:    5'h00,
    ms:     MS_ZERO,
    st:     FLAGS_ZERO,
    mask:   FLAGS_ZERO,
    slp:    1'h0,
    rst_p:  1'h0,
    wake_p: 1'h0,
    ack:    1'h0,
    rdat:   32'h0000_0000
  };

endpackage

// *** hw/wdmc_top.sv ***
/*
  Watchdog timer with configuration selected mode, software control register,
  sticky status with mask and one interrupt, on a classic Wishbone slave.
  Assumes lfosc_i is the free running 31 kHz oscillator, asynchronous to clk_i;
  all other inputs come from logic on clk_i. mode_cfg_i is static after reset.
*/
// Operation
// - The counter advances only on edges of the low frequency oscillator.
// - Every 31 oscillator edges make one nominal millisecond of count.
// - A two bit configuration field picks one of four modes.
// - Mode 11 keeps the watchdog running at all times, Sleep included.
// - Mode 10 runs while awake and stops the watchdog in Sleep.
// - Mode 01 runs only while the software enable bit is set.
// - In mode 01 Sleep has no say in whether the watchdog runs.
// - A prescale field sets a timeout of 2^n ms with n capped at 18, two seconds after reset.
// - Reset, clear, Sleep entry and exit, osc fail, disable and start-up clear it.
// - After wake the count stays clear while the start-up timer runs.
// - A timeout in Sleep wakes the device and sets timeout and powerdown flags.
`timescale 1ns/10ps
module wdmc_top import wdmc_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        lfosc_i,
  input  wire logic [1:0]  mode_cfg_i,
  input  wire logic        sleep_i,
  input  wire logic        watchdog_clear_instr_i,
  input  wire logic        osc_fail_i,
  input  wire logic        ost_running_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             wdt_reset_o,
  output logic             wake_o,
  output logic             active_o,
  output logic             timeout_flag_o,
  output logic             powerdown_flag_o,
  output logic             irq_o
);

  wdmc_state_t     s_q;
  wdmc_state_t     s_d;
  logic            agree;
  logic            rise;
  logic            active;
  logic            hit;
  logic            wr;
  logic            sw_clear;
  logic            clr;
  logic            ms_tick;
  logic            expire;
  logic [4:0]      ps_eff;
  logic [MS_W-1:0] term;
  wdmc_flags_t     set_f;
  wdmc_flags_t     clr_f;

  // Oscillator edge: second and third stages must agree
  assign agree = s_q.sync[1] == s_q.sync[2];
  assign rise  = agree & s_q.sync[2] & ~s_q.lvl;

  always_comb begin
    unique case (s_q.mode)
      WDMC_ON:      active = 1'b1;
      WDMC_NOSLEEP: active = ~sleep_i;
      WDMC_SW:      active = s_q.swen;
      WDMC_OFF:     active = 1'b0;
    endcase
  end

  // Wishbone: ack one cycle after the strobe, write lands on the ack edge
  assign hit      = cyc_i & stb_i;
  assign wr       = hit & we_i & s_q.ack & sel_i[0];
  assign sw_clear = watchdog_clear_instr_i | (wr & (adr_i == ADR_CMD) & dat_i[CMD_CLR]);

  assign clr = sw_clear | (sleep_i != s_q.slp) | osc_fail_i | ~active | ost_running_i;

  assign ps_eff  = (s_q.ps > PS_MAX) ? PS_MAX : s_q.ps;
  assign term    = (MS_W'(1) << ps_eff) - MS_W'(1);
  assign ms_tick = ~clr & rise & (s_q.div == OSC_PER_MS - 5'h01);
  // A count already past a newly shortened period expires at the next tick
  assign expire  = ms_tick & (s_q.ms >= term);

  assign set_f = '{wake: expire & sleep_i, pd: expire & sleep_i, to: expire};
  assign clr_f = (wr & (adr_i == ADR_STATUS)) ? wdmc_flags_t'(dat_i[2:0]) : FLAGS_ZERO;

  always_comb begin
    s_d        = s_q;
    s_d.sync   = {s_q.sync[1:0], lfosc_i};
    s_d.rst_p  = 1'b0;
    s_d.wake_p = 1'b0;
    s_d.slp    = sleep_i;
    if (agree) begin
      s_d.lvl = s_q.sync[2];
    end
    if (!s_q.loaded) begin
      s_d.mode   = wdmc_mode_t'(mode_cfg_i);
      s_d.loaded = 1'b1;
    end
    // Counter
    if (clr) begin
      s_d.div = 5'h00;
      s_d.ms  = MS_ZERO;
    end else if (rise) begin
      if (ms_tick) begin
        s_d.div = 5'h00;
        s_d.ms  = expire ? MS_ZERO : s_q.ms + MS_W'(1);
      end else begin
        s_d.div = s_q.div + 5'h01;
      end
    end
    if (expire) begin
      if (sleep_i) begin
        s_d.wake_p = 1'b1;
      end else begin
        s_d.rst_p = 1'b1;
      end
    end
    // Set wins over a write-one clear
    s_d.st = (s_q.st & ~clr_f) | set_f;
    // Register writes
    if (wr && adr_i == ADR_CTRL) begin
      s_d.swen = dat_i[CTRL_SWEN];
      s_d.ps   = dat_i[CTRL_PS_LSB +: 5];
    end
    if (wr && adr_i == ADR_MASK) begin
      s_d.mask = wdmc_flags_t'(dat_i[2:0]);
    end
    // Bus answer and read data
    s_d.ack = hit & ~s_q.ack;
    if (hit && !s_q.ack) begin
      unique case (adr_i)
        ADR_CTRL:   s_d.rdat = {26'h000_0000, s_q.ps, s_q.swen};
        ADR_STATUS: s_d.rdat = {29'h000_0000, s_q.st};
        ADR_MASK:   s_d.rdat = {29'h000_0000, s_q.mask};
        default:    s_d.rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o            = s_q.rdat;
  assign ack_o            = s_q.ack;
  assign wdt_reset_o      = s_q.rst_p;
  assign wake_o           = s_q.wake_p;
  assign active_o         = active;
  assign timeout_flag_o   = s_q.st.to;
  assign powerdown_flag_o = s_q.st.pd;
  assign irq_o            = |(s_q.st & s_q.mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_osc_edge_only: assert property (
    ($changed(s_q.div) && s_q.div != 5'h00) |-> $past(rise))
    else $error("divider moved without an oscillator edge");

  chk_ms_base: assert property (
    ($changed(s_q.ms) && s_q.ms != MS_ZERO) |-> $past(s_q.div) == OSC_PER_MS - 5'h01)
    else $error("millisecond step before 31 oscillator edges");

  chk_mode_off: assert property (
    (s_q.mode == WDMC_OFF) |-> (!active_o && s_q.div == 5'h00))
    else $error("watchdog active with mode 00");

  chk_always_on: assert property (
    (s_q.mode == WDMC_ON) |-> active_o)
    else $error("mode 11 not active");

  chk_off_in_sleep: assert property (
    (s_q.mode == WDMC_NOSLEEP) |-> (active_o == !sleep_i))
    else $error("mode 10 activity wrong for sleep state");

  chk_sw_enable: assert property (
    (s_q.mode == WDMC_SW) |-> (active_o == s_q.swen))
    else $error("mode 01 activity does not follow enable bit");

  chk_sleep_neutral: assert property (
    (s_q.mode == WDMC_SW && $changed(sleep_i) && $stable(s_q.swen)) |-> $stable(active_o))
    else $error("sleep changed activity in mode 01");

  chk_ps_default: assert property (
    $past(rst_i) |-> (s_q.ps == PS_DEFAULT))
    else $error("prescale not at two second default after reset");

  chk_clear_count: assert property (
    clr |=> (s_q.ms == MS_ZERO && s_q.div == 5'h00))
    else $error("count not cleared");

  chk_ost_hold: assert property (
    ost_running_i [*2] |-> (s_q.div == 5'h00 && s_q.ms == MS_ZERO))
    else $error("count moved during start-up timer");

  chk_sleep_wake: assert property (
    (expire && sleep_i) |=> (wake_o && !wdt_reset_o && timeout_flag_o && powerdown_flag_o))
    else $error("sleep timeout did not wake with flags");

  chk_awake_reset: assert property (
    (expire && !sleep_i) |=> (wdt_reset_o && !wake_o && timeout_flag_o) ##1 !wdt_reset_o)
    else $error("awake timeout did not give one reset pulse");

  // Oscillator, time base and mode
  chk_rise_single: assert property (
    rise |=> !rise)
    else $error("one oscillator edge counted twice");

  chk_div_range: assert property (
    s_q.div < OSC_PER_MS)
    else $error("divider passed one millisecond");

  chk_mode_static: assert property (
    s_q.loaded |=> $stable(s_q.mode))
    else $error("mode changed after it was loaded");

  chk_ps_clamp: assert property (
    ps_eff <= PS_MAX)
    else $error("prescale beyond the longest period");

  chk_sw_set: assert property (
    (wr && adr_i == ADR_CTRL && dat_i[CTRL_SWEN]) |=> s_q.swen)
    else $error("software enable write lost");

  chk_sw_off_hold: assert property (
    (s_q.mode == WDMC_SW && !s_q.swen) |=> (s_q.ms == MS_ZERO && s_q.div == 5'h00))
    else $error("count moved with software enable clear");

  // Clearing conditions
  chk_sleep_change_clr: assert property (
    $changed(sleep_i) |=> (s_q.ms == MS_ZERO && s_q.div == 5'h00))
    else $error("count not cleared on sleep entry or exit");

  chk_watchdog_clear_instr_clr: assert property (
    watchdog_clear_instr_i |=> (s_q.ms == MS_ZERO && s_q.div == 5'h00))
    else $error("count not cleared by clear instruction");

  chk_osc_fail_clr: assert property (
    osc_fail_i |=> (s_q.ms == MS_ZERO && s_q.div == 5'h00))
    else $error("count not cleared on oscillator fail");

  chk_disabled_clr: assert property (
    !active_o |=> (s_q.ms == MS_ZERO && s_q.div == 5'h00))
    else $error("count moved while disabled");

  // Timeout outcomes
  chk_wake_pulse: assert property (
    wake_o |=> !wake_o)
    else $error("wake request longer than one cycle");

  chk_pd_with_wake: assert property (
    $rose(powerdown_flag_o) |-> wake_o)
    else $error("powerdown flag set without a sleep timeout");

  chk_wake_flag: assert property (
    wake_o |-> s_q.st.wake)
    else $error("wake request without wake flag");

  chk_reset_with_flag: assert property (
    wdt_reset_o |-> timeout_flag_o)
    else $error("device reset without timeout flag");

  chk_to_sticky: assert property (
    (timeout_flag_o && !(wr && adr_i == ADR_STATUS && dat_i[0])) |=> timeout_flag_o)
    else $error("timeout flag dropped without a clear");

  // Bus handshake and interrupt
  chk_ack_follows: assert property (
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not acknowledged in one cycle");

  chk_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");

  chk_ack_idle: assert property (
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("acknowledge without a request");

  chk_irq_masked: assert property (
    (s_q.mask == FLAGS_ZERO) |-> !irq_o)
    else $error("interrupt with every source masked");

  cov_awake_timeout: cover property (expire && !sleep_i);
  cov_sleep_timeout: cover property (expire && sleep_i);
  cov_irq_raised:    cover property ($rose(irq_o));
  cov_bus_write:     cover property (wr && adr_i == ADR_CTRL);
  cov_ost_held:      cover property (ost_running_i && active);

endmodule
